// >>> core/bpg_core.sv
// Two-phase boost PWM generator with overvoltage and current limit protection.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/100ps
module bpg_core
    import bpg_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset,
    // Register port
    input  wire bpg_bus_t              bus_req,
    output logic [BPG_DATA_W-1:0]      rd_data,
    // Measurements
    input  wire logic [7:0]            vbst_code,
    input  wire logic [1:0][7:0]       isense_code,
    input  wire logic [1:0]            reg_trip_pin,
    // Gate drive
    output logic [1:0]                 gate_drive,
    // Analog settings
    output bpg_phase_cfg_t [1:0]       phase_cfg,
    output logic [1:0]                 min_on_time_sel,
    // Status
    output logic                       overvoltage_flag,
    output logic [1:0]                 phase_running_flag,
    output logic                       irq
);

    bpg_st_t    q;
    bpg_st_t    d;

    logic       tick;
    logic [6:0] acc_sum;
    logic       src_int;
    logic [7:0] div;
    logic [7:0] div_last;
    logic [7:0] div_half;
    logic       alt_mode;
    logic       pstart;
    logic [1:0] start;

    logic [7:0] ov_thr;
    logic [7:0] hyst;
    logic [7:0] react_lvl;
    logic       ov_now;
    logic       ov_block;

    logic [1:0] gate_w;
    logic [1:0] running_w;
    logic [1:0] limit_evt;
    logic [7:0] track0;
    logic [7:0] track1;

    bpg_evt_t   evt;
    bpg_evt_t   w1c;
    logic [BPG_DATA_W-1:0] state_word;

    // Oscillator tick: a fractional accumulator spreads 16 ticks over 25 clocks.
    assign acc_sum = {1'b0, q.acc} + {1'b0, BPG_ACC_STEP};
    assign tick    = acc_sum >= {1'b0, BPG_ACC_MOD};

    assign src_int  = q.ctrl.pwm_clock_source_sel == BPG_SRC_INTERNAL;
    assign div      = BPG_FREQ_DIV[q.ctrl.internal_pwm_freq_code];
    assign div_last = div - 8'h01;
    assign div_half = {1'b0, div[7:1]};

    // Above the per-phase ceiling the phases take alternate periods.
    assign alt_mode = div < BPG_PHASE_MIN_DIV;
    assign pstart   = src_int & tick & (q.cnt == 8'h00);

    always_comb begin
        start = 2'b00;
        if (alt_mode) begin
            start[0] = pstart & ~q.par;
            start[1] = pstart & q.par;
        end else begin
            start[0] = pstart;
            start[1] = src_int & tick & (q.cnt == div_half);
        end
    end

    // Threshold sum is one bit wider than the setpoint so it cannot wrap.
    assign ov_thr    = {1'b0, q.volt.boost_voltage_target} + {5'b0_0000, q.volt.overvoltage_offset_sel};
    assign hyst      = BPG_HYST[q.volt.overvoltage_reactivation_sel];
    assign react_lvl = (ov_thr > hyst) ? ov_thr - hyst : 8'h00;
    // Detection does not look at the phase enables.
    assign ov_now    = vbst_code > ov_thr;
    assign ov_block  = ov_now | q.ov_shut;

    assign evt.rsvd             = '0;
    assign evt.limit_hit        = limit_evt;
    assign evt.overvoltage_flag = ov_now;

    assign state_word = {13'h0000, track1, track0, q.ov_shut, running_w};

    always_comb begin
        d = q;
        w1c = '0;

        // Two flip-flops before the current loop trip is used.
        d.sync1 = reg_trip_pin;
        d.sync2 = q.sync1;

        if (tick) begin
            d.acc = 6'(acc_sum - {1'b0, BPG_ACC_MOD});
        end else begin
            d.acc = acc_sum[5:0];
        end

        // Period counter runs only from the internal source.
        if (!src_int) begin
            d.cnt = 8'h00;
            d.par = 1'b0;
        end else if (tick) begin
            if (q.cnt >= div_last) begin
                d.cnt = 8'h00;
            end else begin
                d.cnt = q.cnt + 8'h01;
            end
        end
        if (pstart) begin
            d.par = ~q.par;
        end

        // Shutdown holds until the voltage falls below the reactivation level.
        if (ov_now) begin
            d.ov_shut = 1'b1;
        end else if (vbst_code < react_lvl) begin
            d.ov_shut = 1'b0;
        end

        d.rdata = '0;
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                BPG_CTRL_OFS: begin
                    d.ctrl      = bpg_ctrl_t'(bus_req.wdata);
                    d.ctrl.rsvd = '0;
                end
                BPG_VOLT_OFS: begin
                    d.volt      = bpg_volt_t'(bus_req.wdata);
                    d.volt.rsvd = '0;
                end
                BPG_PH0_OFS: begin
                    d.ph[0]      = bpg_phase_reg_t'(bus_req.wdata);
                    d.ph[0].rsvd = '0;
                end
                BPG_PH1_OFS: begin
                    d.ph[1]      = bpg_phase_reg_t'(bus_req.wdata);
                    d.ph[1].rsvd = '0;
                end
                BPG_STATUS_OFS: begin
                    w1c = bpg_evt_t'(bus_req.wdata);
                end
                BPG_MASK_OFS: begin
                    d.mask      = bpg_evt_t'(bus_req.wdata);
                    d.mask.rsvd = '0;
                end
                default: begin
                end
            endcase
        end

        // A new event in the clearing cycle keeps its bit set.
        d.status      = (q.status & ~w1c) | evt;
        d.status.rsvd = '0;

        if (bus_req.rd) begin
            unique case (bus_req.addr)
                BPG_CTRL_OFS: begin
                    d.rdata = q.ctrl;
                end
                BPG_VOLT_OFS: begin
                    d.rdata = q.volt;
                end
                BPG_PH0_OFS: begin
                    d.rdata = q.ph[0];
                end
                BPG_PH1_OFS: begin
                    d.rdata = q.ph[1];
                end
                BPG_STATUS_OFS: begin
                    d.rdata = q.status;
                end
                BPG_MASK_OFS: begin
                    d.rdata = q.mask;
                end
                BPG_STATE_OFS: begin
                    d.rdata = state_word;
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end
    end

    // Reset leaves both phases off and the setpoint at its minimum.
    always_ff @(posedge mclk) begin
        if (reset) begin
            q <= BPG_ST_RST;
        end else begin
            q <= d;
        end
    end

    bpg_phase u_phase0 (
        .mclk        (mclk),
        .reset       (reset),
        .start       (start[0]),
        .enable      (q.ctrl.phase_enable[0]),
        .ov_block    (ov_block),
        .step        (q.volt.limit_tracking_step),
        .limit_sel   (q.ph[0].cfg.peak_current_limit_sel),
        .reg_trip    (q.sync2[0]),
        .isense      (isense_code[0]),
        .gate        (gate_w[0]),
        .running     (running_w[0]),
        .limit_event (limit_evt[0]),
        .track       (track0)
    );

    bpg_phase u_phase1 (
        .mclk        (mclk),
        .reset       (reset),
        .start       (start[1]),
        .enable      (q.ctrl.phase_enable[1]),
        .ov_block    (ov_block),
        .step        (q.volt.limit_tracking_step),
        .limit_sel   (q.ph[1].cfg.peak_current_limit_sel),
        .reg_trip    (q.sync2[1]),
        .isense      (isense_code[1]),
        .gate        (gate_w[1]),
        .running     (running_w[1]),
        .limit_event (limit_evt[1]),
        .track       (track1)
    );

    assign rd_data            = q.rdata;
    assign gate_drive         = gate_w;
    assign phase_cfg[0]       = q.ph[0].cfg;
    assign phase_cfg[1]       = q.ph[1].cfg;
    assign min_on_time_sel    = q.ctrl.min_on_time_sel;
    assign overvoltage_flag   = q.status.overvoltage_flag;
    assign phase_running_flag = running_w;
    assign irq                = |(q.status & q.mask);

endmodule : bpg_core

// >>> core/bpg_phase.sv
// One boost phase: gate pulse, peak current limit with threshold tracking.
`timescale 1ns/100ps
module bpg_phase
    import bpg_pkg::*;
(
    // Clock and reset
    input  wire logic           mclk,
    input  wire logic           reset,
    // Period timing and control
    input  wire logic           start,
    input  wire logic           enable,
    input  wire logic           ov_block,
    input  wire logic [3:0]     step,
    input  wire logic [7:0]     limit_sel,
    // Sense
    input  wire logic           reg_trip,
    input  wire logic [7:0]     isense,
    // Results
    output logic                gate,
    output logic                running,
    output logic                limit_event,
    output logic [7:0]          track
);

    bpg_phase_st_t q;
    bpg_phase_st_t d;
    logic [8:0]    floor9;
    logic [8:0]    up9;

    assign floor9 = {2'b00, limit_sel[7:1]};
    assign up9    = {1'b0, q.track} + {5'b0_0000, step};

    always_comb begin
        d = q;
        d.limit_event = 1'b0;
        if (q.track > limit_sel) begin
            d.track = limit_sel;
        end
        if (start) begin
            // Step down after a limited period, recover towards the setting otherwise.
            if (q.hit) begin
                if ({1'b0, q.track} >= floor9 + {5'b0_0000, step}) begin
                    d.track = q.track - {4'h0, step};
                end else begin
                    d.track = floor9[7:0];
                end
            end else if (up9 <= {1'b0, limit_sel}) begin
                d.track = up9[7:0];
            end else begin
                d.track = limit_sel;
            end
            d.hit     = 1'b0;
            d.gate    = enable & ~ov_block;
            d.running = enable & ~ov_block;
        end
        if (q.gate && isense >= q.track) begin
            d.gate        = 1'b0;
            d.hit         = 1'b1;
            d.limit_event = 1'b1;
        end
        if (q.gate && reg_trip) begin
            d.gate = 1'b0;
        end
        // Gate stays off until a later start, so the rest of the period is skipped.
        if (ov_block) begin
            d.gate    = 1'b0;
            d.running = 1'b0;
        end
        if (!enable) begin
            d.gate    = 1'b0;
            d.running = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign gate        = q.gate;
    assign running     = q.running;
    assign limit_event = q.limit_event;
    assign track       = q.track;

endmodule : bpg_phase

// >>> core/bpg_pkg.sv
// Constants, register layouts and state types of the boost PWM protection generator.
// Overview of operation
// - Overvoltage threshold is setpoint plus offset code.
// - Overvoltage forces gates off for the period.
// - Overvoltage sets flag, clears phase running flags.
// - Restart only below hysteresis level, skipping periods.
// - Overvoltage detection works with phases disabled.
// - Overvoltage flag may read set after reset.
// - Per-phase 3-bit compensation divider selection.
// - Per-phase 3-bit slope compensation, zero disables.
// - Gate off when sensed current reaches limit.
// - Limit threshold tracks in programmable regulation steps.
// - Clock source one uses internal oscillator.
// - Five-bit code selects 125 kHz to 4 MHz.
// - Phases alternate periods above 2 MHz per phase.
// - Reset disables phases, setpoint all zeros.
// - Source select: off, internal, external, automatic; external and automatic act as off here.
package bpg_pkg;

    localparam int BPG_ADDR_W = 8;
    localparam int BPG_DATA_W = 32;

    localparam logic [BPG_ADDR_W-1:0] BPG_CTRL_OFS   = 8'h00;
    localparam logic [BPG_ADDR_W-1:0] BPG_VOLT_OFS   = 8'h04;
    localparam logic [BPG_ADDR_W-1:0] BPG_PH0_OFS    = 8'h08;
    localparam logic [BPG_ADDR_W-1:0] BPG_PH1_OFS    = 8'h0c;
    localparam logic [BPG_ADDR_W-1:0] BPG_STATUS_OFS = 8'h10;
    localparam logic [BPG_ADDR_W-1:0] BPG_MASK_OFS   = 8'h14;
    localparam logic [BPG_ADDR_W-1:0] BPG_STATE_OFS  = 8'h18;

    // Oscillator and system clock rates in kHz.
    localparam int BPG_OSC_KHZ       = 16000;
    localparam int BPG_MCLK_KHZ      = 25000;
    localparam int BPG_PHASE_MAX_KHZ = 2000;
    localparam logic [5:0] BPG_ACC_STEP = 6'(BPG_OSC_KHZ / 1000);
    localparam logic [5:0] BPG_ACC_MOD  = 6'(BPG_MCLK_KHZ / 1000);
    localparam logic [7:0] BPG_PHASE_MIN_DIV = 8'(BPG_OSC_KHZ / BPG_PHASE_MAX_KHZ);

    // Oscillator divider per frequency code, 125 kHz up to 4 MHz.
    localparam logic [7:0] BPG_FREQ_DIV [0:31] = '{
        8'h80, 8'h72, 8'h64, 8'h5b, 8'h50, 8'h48, 8'h40, 8'h3a,
        8'h35, 8'h30, 8'h2a, 8'h24, 8'h20, 8'h1d, 8'h1b, 8'h18,
        8'h16, 8'h14, 8'h12, 8'h10, 8'h0f, 8'h0e, 8'h0d, 8'h0c,
        8'h0b, 8'h0a, 8'h09, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04};

    // Reactivation hysteresis in converter steps below the threshold.
    localparam logic [7:0] BPG_HYST [0:3] = '{8'h02, 8'h04, 8'h06, 8'h08};

    typedef enum logic [1:0] {
        BPG_SRC_OFF,
        BPG_SRC_INTERNAL,
        BPG_SRC_EXTERNAL,
        BPG_SRC_AUTO
    } bpg_src_t;

    typedef struct packed {
        logic [20:0] rsvd;
        logic [1:0]  min_on_time_sel;
        logic [4:0]  internal_pwm_freq_code;
        bpg_src_t    pwm_clock_source_sel;
        logic [1:0]  phase_enable;
    } bpg_ctrl_t;

    typedef struct packed {
        logic [15:0] rsvd;
        logic [3:0]  limit_tracking_step;
        logic [1:0]  overvoltage_reactivation_sel;
        logic [2:0]  overvoltage_offset_sel;
        logic [6:0]  boost_voltage_target;
    } bpg_volt_t;

    typedef struct packed {
        logic [7:0] peak_current_limit_sel;
        logic [2:0] slope_comp_sel;
        logic [2:0] comp_divider_sel;
    } bpg_phase_cfg_t;

    typedef struct packed {
        logic [17:0]    rsvd;
        bpg_phase_cfg_t cfg;
    } bpg_phase_reg_t;

    typedef struct packed {
        logic [28:0] rsvd;
        logic [1:0]  limit_hit;
        logic        overvoltage_flag;
    } bpg_evt_t;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [BPG_ADDR_W-1:0] addr;
        logic [BPG_DATA_W-1:0] wdata;
    } bpg_bus_t;

    typedef struct packed {
        logic       gate;
        logic       running;
        logic       hit;
        logic       limit_event;
        logic [7:0] track;
    } bpg_phase_st_t;

    typedef struct packed {
        logic [1:0]            sync1;
        logic [1:0]            sync2;
        logic [5:0]            acc;
        logic [7:0]            cnt;
        logic                  par;
        logic                  ov_shut;
        bpg_ctrl_t             ctrl;
        bpg_volt_t             volt;
        bpg_phase_reg_t [1:0]  ph;
        bpg_evt_t              status;
        bpg_evt_t              mask;
        logic [BPG_DATA_W-1:0] rdata;
    } bpg_st_t;

    localparam logic [3:0] BPG_STEP_RST = 4'h1;
    localparam bpg_st_t    BPG_ST_RST   = '{volt: '{limit_tracking_step: BPG_STEP_RST, default: '0},
                                            default: '0};

endpackage : bpg_pkg

// >>> verif/bpg_core_bench.sv
// Self-checking bench for the boost PWM protection generator.
`timescale 1ns/100ps
module bpg_core_bench
    import bpg_pkg::*;
;
    logic                  mclk = 1'b0;
    logic                  reset = 1'b1;
    bpg_bus_t              bus_req = '0;
    logic [7:0]            vbst_level = 8'h00;
    logic [7:0]            trip_level = 8'hff;
    logic [BPG_DATA_W-1:0] rd_data;
    logic [7:0]            vbst_code;
    logic [1:0][7:0]       isense_code;
    logic [1:0]            reg_trip_pin, gate_drive, min_on_time_sel, phase_running_flag;
    bpg_phase_cfg_t [1:0]  phase_cfg;
    logic                  overvoltage_flag, irq;
    int                    errors = 0;
    int                    samples_checked = 0;
    initial begin
        forever #20 mclk = ~mclk;
    end
    bpg_core dut (.mclk(mclk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data), .vbst_code(vbst_code),
        .isense_code(isense_code), .reg_trip_pin(reg_trip_pin), .gate_drive(gate_drive), .phase_cfg(phase_cfg),
        .min_on_time_sel(min_on_time_sel), .overvoltage_flag(overvoltage_flag),
        .phase_running_flag(phase_running_flag), .irq(irq));
    bpg_power_stage stage (.mclk(mclk), .gate_drive(gate_drive), .vbst_level(vbst_level),
        .trip_level(trip_level), .vbst_code(vbst_code), .isense_code(isense_code), .reg_trip_pin(reg_trip_pin));
    task automatic conclude();
        $display("Checks %0d, mismatches %0d.", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        bus_req <= '0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge mclk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge mclk);
        bus_req <= '0;
        @(posedge mclk);
        chk(rd_data & m, exp);
    endtask : rdchk
    // Counts rising gate edges of phase 0; span is the cycle distance from the first to the last.
    task automatic watch(input int lim, input int n, output int k, output int span);
        int   c;
        int   t0;
        logic p;
        k = 0;
        c = 0;
        t0 = 0;
        p = gate_drive[0];
        while (k <= n && c < lim) begin
            @(posedge mclk);
            c++;
            if (gate_drive[0] && !p) begin
                if (k == 0) t0 = c;
                k++;
            end
            p = gate_drive[0];
        end
        span = c - t0;
    endtask : watch
    task automatic t_reset();
        rdchk(BPG_CTRL_OFS, 32'hffffffff, 32'h0);
        rdchk(BPG_VOLT_OFS, 32'hffffffff, 32'h1000);
        rdchk(BPG_PH0_OFS, 32'hffffffff, 32'h0);
        rdchk(BPG_STATE_OFS, 32'hffffffff, 32'h0);
        rdchk(8'h1c, 32'hffffffff, 32'h0);
        rdchk(BPG_STATUS_OFS, 32'hfffffffe, 32'h0);
        $display("Test reset done.");
    endtask : t_reset
    task automatic t_cfg();
        logic [31:0] d;
        for (int k = 0; k < 8; k++) begin
            d = {18'h0, 8'h10, 3'(k), 3'(7 - k)};
            wr(BPG_PH0_OFS, d);
            wr(BPG_PH1_OFS, ~d & 32'h3fff);
            @(negedge mclk);
            chk(32'(phase_cfg[0]), d);
            chk(32'(phase_cfg[1]), ~d & 32'h3fff);
        end
        $display("Test settings done.");
    endtask : t_cfg
    task automatic t_freq();
        int khz [9] = '{125, 140, 160, 176, 727, 800, 889, 1000, 4000};
        int code [9] = '{0, 1, 2, 3, 16, 17, 18, 19, 31};
        int per, exp, k, span;
        foreach (khz[i]) begin
            per = (16000 + khz[i] / 2) / khz[i];
            if (khz[i] > 2000) per = 2 * per;
            exp = (per * 200 + 8) / 16;
            wr(BPG_CTRL_OFS, 32'(code[i] << 4) | 32'h7);
            watch(5000, 1, k, span);
            watch(5000, 8, k, span);
            samples_checked++;
            if (k != 9 || span < exp - 1 || span > exp + 1) begin
                errors++;
                $display("ERROR t=%0t got=%h exp=%h", $time, span, exp);
                if (k != 9) conclude();
            end
        end
        $display("Test frequency done.");
    endtask : t_freq
    task automatic t_src();
        int k, span;
        for (int s = 0; s < 4; s += 1 + (s == 0)) begin
            wr(BPG_CTRL_OFS, 32'(s << 2) | 32'h133);
            // A period started just before the write may still raise the gate at its edge.
            @(posedge mclk);
            watch(300, 99, k, span);
            chk(k, 0);
        end
        $display("Test source done.");
    endtask : t_src
    task automatic t_limit();
        int k, span;
        wr(BPG_VOLT_OFS, 32'h407f);
        wr(BPG_PH0_OFS, 32'h1000);
        wr(BPG_STATUS_OFS, 32'h6);
        wr(BPG_CTRL_OFS, 32'h735);
        watch(2000, 30, k, span);
        chk(k, 31);
        chk(min_on_time_sel, 2'b11);
        rdchk(BPG_STATE_OFS, 32'h7f8, 32'h100);
        rdchk(BPG_STATUS_OFS, 32'h2, 32'h2);
        $display("Test limit done.");
    endtask : t_limit
    task automatic t_ov();
        int k, span;
        wr(BPG_CTRL_OFS, 32'h134);
        wr(BPG_VOLT_OFS, 32'h15a0);
        vbst_level <= 8'h23;
        wr(BPG_STATUS_OFS, 32'h7);
        @(negedge mclk);
        chk(overvoltage_flag, 1'b0);
        @(posedge mclk);
        vbst_level <= 8'h24;
        repeat (2) @(negedge mclk);
        chk(overvoltage_flag, 1'b1);
        wr(BPG_MASK_OFS, 32'h1);
        @(negedge mclk);
        chk(irq, 1'b1);
        wr(BPG_STATUS_OFS, 32'h1);
        @(negedge mclk);
        chk(overvoltage_flag, 1'b1);
        wr(BPG_CTRL_OFS, 32'h137);
        vbst_level <= 8'h20;
        watch(300, 99, k, span);
        chk(k, 0);
        chk(phase_running_flag, 2'b00);
        vbst_level <= 8'h1e;
        watch(300, 0, k, span);
        chk(k, 1);
        wr(BPG_STATUS_OFS, 32'h1);
        @(negedge mclk);
        chk(irq, 1'b0);
        @(posedge mclk);
        vbst_level <= 8'h24;
        @(posedge mclk);
        @(negedge mclk);
        chk({gate_drive, phase_running_flag, irq}, 5'h01);
        $display("Test overvoltage done.");
    endtask : t_ov
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_cfg();
        t_freq();
        t_src();
        t_limit();
        t_ov();
        conclude();
    end
endmodule : bpg_core_bench
bind bpg_core bpg_core_monitor mon (.mclk(mclk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
    .vbst_code(vbst_code), .isense_code(isense_code), .gate_drive(gate_drive), .phase_cfg(phase_cfg),
    .min_on_time_sel(min_on_time_sel), .overvoltage_flag(overvoltage_flag), .phase_running_flag(phase_running_flag));

// >>> verif/bpg_core_monitor.sv
// Port checker for the boost PWM protection generator.
`timescale 1ns/100ps
module bpg_core_monitor
    import bpg_pkg::*;
(
    // Clock and reset
    input wire logic                  mclk,
    input wire logic                  reset,
    // Register port
    input wire bpg_bus_t              bus_req,
    input wire logic [BPG_DATA_W-1:0] rd_data,
    // Measurements and outputs
    input wire logic [7:0]            vbst_code,
    input wire logic [1:0][7:0]       isense_code,
    input wire logic [1:0]            gate_drive,
    input wire bpg_phase_cfg_t [1:0]  phase_cfg,
    input wire logic [1:0]            min_on_time_sel,
    input wire logic                  overvoltage_flag,
    input wire logic [1:0]            phase_running_flag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    bpg_ctrl_t  ctrl_q;
    bpg_volt_t  volt_q;
    logic       shut_q;
    logic [7:0] thr;
    assign thr = {1'b0, volt_q.boost_voltage_target} + 8'(volt_q.overvoltage_offset_sel);
    // Shadow copies of the settings, since the checker sees only the ports.
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_q <= '0;
            volt_q <= '0;
            shut_q <= 1'b0;
        end else begin
            if (bus_req.wr && bus_req.addr == BPG_CTRL_OFS) ctrl_q <= bus_req.wdata;
            if (bus_req.wr && bus_req.addr == BPG_VOLT_OFS) volt_q <= bus_req.wdata;
            if (vbst_code > thr) shut_q <= 1'b1;
            else if (int'(vbst_code) < int'(thr) - int'(BPG_HYST[volt_q.overvoltage_reactivation_sel])) shut_q <= 1'b0;
        end
    end
    property p_ov_flag;
        vbst_code > thr |=> overvoltage_flag;
    endproperty
    a_ov_flag: assert property (p_ov_flag) else $error("Overvoltage flag missed.");
    property p_ov_gate;
        vbst_code > thr |=> gate_drive == 2'b00 && phase_running_flag == 2'b00;
    endproperty
    a_ov_gate: assert property (p_ov_gate) else $error("Gate or running flag on in overvoltage.");
    property p_hold_off;
        shut_q |-> gate_drive == 2'b00;
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("Gate restarted above hysteresis.");
    property p_no_pulse;
        |(gate_drive & ~$past(gate_drive)) |-> $past(ctrl_q.pwm_clock_source_sel) == BPG_SRC_INTERNAL
            && (gate_drive & ~$past(gate_drive) & ~$past(ctrl_q.phase_enable)) == 2'b00;
    endproperty
    a_no_pulse: assert property (p_no_pulse) else $error("Pulse without internal source.");
    property p_limit;
        isense_code[0] >= phase_cfg[0].peak_current_limit_sel |=> !gate_drive[0];
    endproperty
    a_limit: assert property (p_limit) else $error("Gate stayed on at current limit.");
    property p_cfg;
        bus_req.wr && bus_req.addr == BPG_PH0_OFS |=> phase_cfg[0] == $past(bus_req.wdata[13:0]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("Phase settings not applied.");
    property p_status_rd;
        bus_req.rd && bus_req.addr == BPG_STATUS_OFS |=> rd_data[0] == $past(overvoltage_flag);
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("Status read disagrees with flag.");
    property p_reset;
        $fell(reset) |-> gate_drive == 2'b00 && phase_running_flag == 2'b00 && !overvoltage_flag
            && phase_cfg == '0 && min_on_time_sel == 2'b00;
    endproperty
    a_reset: assert property (p_reset) else $error("Outputs not at reset values.");
endmodule : bpg_core_monitor

// >>> verif/bpg_power_stage.sv
// Behavioural power stage: boost voltage sense and inductor current ramp.
`timescale 1ns/100ps
module bpg_power_stage (
    // Clock
    input  wire logic       mclk,
    // Controller gate drive
    input  wire logic [1:0] gate_drive,
    // Levels set by the bench
    input  wire logic [7:0] vbst_level,
    input  wire logic [7:0] trip_level,
    // Sense outputs
    output logic [7:0]      vbst_code,
    output logic [1:0][7:0] isense_code,
    output logic [1:0]      reg_trip_pin
);
    logic [1:0][7:0] ramp_q = '0;
    // The voltage code is the bench level passed straight through, even above the setpoint plus offset limit.
    assign vbst_code = vbst_level;
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 2; i++) begin
            // Saturate rather than wrap, so a stuck gate never looks like a fresh low current.
            ramp_q[i] <= gate_drive[i] ? (ramp_q[i] > 8'hfb ? 8'hff : ramp_q[i] + 8'h04) : 8'h00;
        end
    end
    assign isense_code  = ramp_q;
    assign reg_trip_pin = {ramp_q[1] >= trip_level, ramp_q[0] >= trip_level};
endmodule : bpg_power_stage
